//--- logic/quad_conv_params.svh
`ifndef QUAD_CONV_PARAMS_SVH
`define QUAD_CONV_PARAMS_SVH

// ----------------------------------------
// codes and word layout
// ----------------------------------------
`define CODE_W          12
`define WORD_W          16
`define CHAN_N          4
`define CODE_ZERO_SCALE 12'h000
`define CODE_MID_SCALE  12'h800
`define WORD_SEL_HI     15
`define WORD_SEL_LO     14
`define WORD_CODE_MSB   11

// ----------------------------------------
// synchroniser idle level
// ----------------------------------------
`define SYNC_IDLE       1'b1

`endif

//--- logic/quad_conv_pkg.sv
package quad_conv_pkg;
	typedef logic [11:0] code_t;
	typedef logic [15:0] word_t;
	typedef logic [1:0]  chan_t;
endpackage

//--- logic/serial_word_shifter.sv
`timescale 1ns/100ps
`include "quad_conv_params.svh"

// ----------------------------------------
// shift register clocked by sampled shift-control edges
// ----------------------------------------
module serial_word_shifter
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// synchronised pins
	input  wire logic                  shift_ctl,
	input  wire logic                  data_bit,
	// shifted word
	output quad_conv_pkg::word_t       word
);
	typedef struct packed
	{
		logic                 ctl_d;
		quad_conv_pkg::word_t sr;
	} shf_s;

	shf_s st_r;
	shf_s st_nxt;

	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.ctl_d = shift_ctl;
		// rising edge of cs OR clk: advance one bit, msb first
		if (shift_ctl && !st_r.ctl_d)
			st_nxt.sr = {st_r.sr[`WORD_W-2:0], data_bit};
	end

	// the device reset leaves the shift register alone; only power-up clears it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_r <= '{ctl_d: 1'b1, sr: 16'h0000};
		else
			st_r <= st_nxt;
	end

	assign word = st_r.sr;
endmodule // serial_word_shifter

//--- logic/quad_conv_control.sv
`timescale 1ns/100ps
`include "quad_conv_params.svh"

// Operation
// - while reset is low every input and output register is forced to the reset code, from the third clock edge that samples it low.
// - the reset code is 000 hex with the select low and 800 hex with it high.
// - output registers follow input registers while the load-all strobe is low, else hold.
// - only the addressed input register follows the shifted code while the load strobe is low.
// - each channel has an input stage followed by a separate output stage.
// - four channels of 12-bit codes, loaded through a serial input.
// - a word is 16 bits, two select bits, two unused bits, then the code msb first.
// - the shift register advances on each rising edge of chip select OR serial clock.
// - reset leaves latched registers at the reset code on release and never touches the shifter.

module quad_conv_control
(
	// system
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	// serial pins
	input  wire logic                  SERIAL_CLK,
	input  wire logic                  CHIP_SELECT_N,
	input  wire logic                  SERIAL_WORD_IN,
	// control pins
	input  wire logic                  INPUT_LOAD_STROBE_N,
	input  wire logic                  LOAD_ALL_OUTPUTS_N,
	input  wire logic                  RESET_N,
	input  wire logic                  RESET_CODE_SELECT,
	// converter codes
	output quad_conv_pkg::code_t       OUT_CODE_A,
	output quad_conv_pkg::code_t       OUT_CODE_B,
	output quad_conv_pkg::code_t       OUT_CODE_C,
	output quad_conv_pkg::code_t       OUT_CODE_D,
	// addressed channel of the shifted word
	output quad_conv_pkg::chan_t       CHANNEL_SELECT
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed
	{
		// first synchroniser stage, may be metastable
		logic                          serial_clk_m;
		logic                          cs_n_m;
		logic                          sdi_m;
		logic                          ld_n_m;
		logic                          ldall_n_m;
		logic                          rst_n_m;
		logic                          sel_m;
		// second stage, the only one that logic reads
		logic                          serial_clk_q;
		logic                          cs_n_q;
		logic                          sdi_q;
		logic                          ld_n_q;
		logic                          ldall_n_q;
		logic                          rst_n_q;
		logic                          sel_q;
		// double-buffered channel stages
		quad_conv_pkg::code_t [3:0]    in_reg;
		quad_conv_pkg::code_t [3:0]    out_reg;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	// ----------------------------------------
	// power-up value
	// ----------------------------------------
	// pins idle high, so no false shift edge follows power-up
	localparam ctl_s ctl_power_up = '{
		serial_clk_m: `SYNC_IDLE,
		cs_n_m:       `SYNC_IDLE,
		sdi_m:        `SYNC_IDLE,
		ld_n_m:       `SYNC_IDLE,
		ldall_n_m:    `SYNC_IDLE,
		rst_n_m:      `SYNC_IDLE,
		sel_m:        `SYNC_IDLE,
		serial_clk_q: `SYNC_IDLE,
		cs_n_q:       `SYNC_IDLE,
		sdi_q:        `SYNC_IDLE,
		ld_n_q:       `SYNC_IDLE,
		ldall_n_q:    `SYNC_IDLE,
		rst_n_q:      `SYNC_IDLE,
		sel_q:        `SYNC_IDLE,
		in_reg:       {`CHAN_N{`CODE_ZERO_SCALE}},
		out_reg:      {`CHAN_N{`CODE_ZERO_SCALE}}
	};

	// ----------------------------------------
	// synchronised pins
	// ----------------------------------------
	logic                 clk_s;
	logic                 cs_n_s;
	logic                 sdi_s;
	logic                 ld_n_s;
	logic                 ldall_n_s;
	logic                 rst_n_s;
	logic                 sel_s;
	logic                 shift_ctl;
	logic [3:0]           chan_hit;
	quad_conv_pkg::word_t word;
	quad_conv_pkg::code_t rst_code;
	quad_conv_pkg::chan_t chan;

	assign clk_s     = st_r.serial_clk_q;
	assign cs_n_s    = st_r.cs_n_q;
	assign sdi_s     = st_r.sdi_q;
	assign ld_n_s    = st_r.ld_n_q;
	assign ldall_n_s = st_r.ldall_n_q;
	assign rst_n_s   = st_r.rst_n_q;
	// select shares the reset path latency, so a changed strap is seen in time
	assign sel_s     = st_r.sel_q;

	// ----------------------------------------
	// decoders
	// ----------------------------------------
	function automatic quad_conv_pkg::code_t reset_code(input logic sel);
		reset_code = sel ? `CODE_MID_SCALE : `CODE_ZERO_SCALE;
	endfunction

	function automatic logic addr_match
	(
		input quad_conv_pkg::chan_t sel,
		input quad_conv_pkg::chan_t idx
	);
		addr_match = (sel == idx);
	endfunction

	// ----------------------------------------
	// channel address decode
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `CHAN_N; g++)
		begin : g_chan
			assign chan_hit[g] = addr_match(chan, 2'(g));
		end
	endgenerate

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	// either pin can clock alone; the other is parked low
	assign shift_ctl = clk_s | cs_n_s;

	serial_word_shifter u_shift
	(
		.clk       (CLOCK),
		.rst       (RST),
		.shift_ctl (shift_ctl),
		.data_bit  (sdi_s),
		.word      (word)
	); // reset pin not connected to shifter

	assign chan     = {word[`WORD_SEL_HI], word[`WORD_SEL_LO]};
	assign rst_code = reset_code(sel_s);

	// ----------------------------------------
	// double-buffered channel registers
	// ----------------------------------------
	always_comb
	begin
		st_nxt              = st_r;
		// stage one samples the pins, stage two the first stage
		st_nxt.serial_clk_m = SERIAL_CLK;
		st_nxt.cs_n_m       = CHIP_SELECT_N;
		st_nxt.sdi_m        = SERIAL_WORD_IN;
		st_nxt.ld_n_m       = INPUT_LOAD_STROBE_N;
		st_nxt.ldall_n_m    = LOAD_ALL_OUTPUTS_N;
		st_nxt.rst_n_m      = RESET_N;
		st_nxt.sel_m        = RESET_CODE_SELECT;
		st_nxt.serial_clk_q = st_r.serial_clk_m;
		st_nxt.cs_n_q       = st_r.cs_n_m;
		st_nxt.sdi_q        = st_r.sdi_m;
		st_nxt.ld_n_q       = st_r.ld_n_m;
		st_nxt.ldall_n_q    = st_r.ldall_n_m;
		st_nxt.rst_n_q      = st_r.rst_n_m;
		st_nxt.sel_q        = st_r.sel_m;
		for (int i = 0; i < `CHAN_N; i++)
		begin
			// reset wins over both load strobes
			if (!rst_n_s)
			begin
				st_nxt.in_reg[i]  = rst_code;
				st_nxt.out_reg[i] = rst_code;
			end
			else
			begin
				// latched stages simply keep the reset code after release
				if (!ld_n_s && chan_hit[i])
				begin
					st_nxt.in_reg[i] = word[`WORD_CODE_MSB:0];
				end
				// transparent output sees this cycle's input stage
				if (!ldall_n_s)
				begin
					st_nxt.out_reg[i] = st_nxt.in_reg[i];
				end
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// power-up state only; the pin reset is sampled like any other input
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			st_r <= ctl_power_up;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign OUT_CODE_A     = st_r.out_reg[0];
	assign OUT_CODE_B     = st_r.out_reg[1];
	assign OUT_CODE_C     = st_r.out_reg[2];
	assign OUT_CODE_D     = st_r.out_reg[3];
	assign CHANNEL_SELECT = chan;
endmodule // quad_conv_control

//--- dv/quad_conv_asserts.sv
`timescale 1ns/100ps
module quad_conv_asserts
(
	// pins and codes
	input wire logic           CLOCK, RST, RESET_N, RESET_CODE_SELECT, SERIAL_CLK, CHIP_SELECT_N,
	input wire logic           LOAD_ALL_OUTPUTS_N, INPUT_LOAD_STROBE_N,
	input quad_conv_pkg::code_t OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D,
	input quad_conv_pkg::chan_t CHANNEL_SELECT
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire logic [47:0] codes = {OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D};
	wire logic [47:0] rc = RESET_CODE_SELECT ? {4{12'h800}} : {4{12'h000}};
	wire logic        idle = RESET_N && INPUT_LOAD_STROBE_N;
	property p_rs; !RESET_N[*4] |-> codes == rc; endproperty
	a_rs: assert property (p_rs) else $error("reset code");
	property p_mid; RESET_CODE_SELECT && !RESET_N[*4] |-> OUT_CODE_B == 12'h800; endproperty
	a_mid: assert property (p_mid) else $error("mid code");
	property p_hd; (LOAD_ALL_OUTPUTS_N && RESET_N)[*5] |=> $stable(codes); endproperty
	a_hd: assert property (p_hd) else $error("held code moved");
	property p_ia; (!LOAD_ALL_OUTPUTS_N && idle)[*5] |=> $stable(codes); endproperty
	a_ia: assert property (p_ia) else $error("latched input moved");
	property p_sel;
		(!INPUT_LOAD_STROBE_N && CHIP_SELECT_N && RESET_N && CHANNEL_SELECT == 2'h0)[*5]
			|=> $stable(codes[35:0]);
	endproperty
	a_sel: assert property (p_sel) else $error("unaddressed moved");
	property p_sh; (SERIAL_CLK || CHIP_SELECT_N)[*4] |=> $stable(CHANNEL_SELECT); endproperty
	a_sh: assert property (p_sh) else $error("shift without edge");
	property p_rsh; (!RESET_N && CHIP_SELECT_N)[*4] |=> $stable(CHANNEL_SELECT); endproperty
	a_rsh: assert property (p_rsh) else $error("reset hit shifter");
	property p_rl; !RESET_N[*4] ##1 (idle && LOAD_ALL_OUTPUTS_N)[*6] |-> codes == rc; endproperty
	a_rl: assert property (p_rl) else $error("release lost code");
	cover property (!LOAD_ALL_OUTPUTS_N);
	cover property (!INPUT_LOAD_STROBE_N);
	cover property (!RESET_N && RESET_CODE_SELECT);
endmodule // quad_conv_asserts
bind quad_conv_control quad_conv_asserts chk (.*);

//--- dv/host_ctl.sv
`timescale 1ns/100ps
module host_ctl
(
	// serial and strobe pins
	output logic SERIAL_CLK, CHIP_SELECT_N, SERIAL_WORD_IN, INPUT_LOAD_STROBE_N, LOAD_ALL_OUTPUTS_N
);
	initial {SERIAL_CLK, CHIP_SELECT_N, SERIAL_WORD_IN, INPUT_LOAD_STROBE_N, LOAD_ALL_OUTPUTS_N} = 5'h1F;
	task automatic upd();
		LOAD_ALL_OUTPUTS_N = 0;
		#100 LOAD_ALL_OUTPUTS_N = 1;
		#100;
	endtask
	// alt: clock parked low, chip select makes the edges
	task automatic send(input logic [15:0] w, input logic all, alt);
		SERIAL_CLK = !alt;
		CHIP_SELECT_N = alt;
		for (int i = 15; i >= 0; i--)
		begin
			if (alt) CHIP_SELECT_N = 0; else SERIAL_CLK = 0;
			SERIAL_WORD_IN = w[i];
			#62.5;
			if (alt) CHIP_SELECT_N = 1; else SERIAL_CLK = 1;
			#62.5;
		end
		CHIP_SELECT_N = 1;
		SERIAL_CLK = 1;
		SERIAL_WORD_IN = ~w[0];
		INPUT_LOAD_STROBE_N = 0;
		#100 INPUT_LOAD_STROBE_N = 1;
		#100;
		if (all) upd();
	endtask
endmodule // host_ctl

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic CLOCK = 0, RST = 1, RESET_N = 1, RESET_CODE_SELECT = 0;
	wire logic SERIAL_CLK, CHIP_SELECT_N, SERIAL_WORD_IN, INPUT_LOAD_STROBE_N, LOAD_ALL_OUTPUTS_N;
	quad_conv_pkg::code_t OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D;
	quad_conv_pkg::chan_t CHANNEL_SELECT;
	int num_errors = 0, tests_run = 0, cycles = 0;
	// word sent, code expected on its channel; ignored bits set in some
	logic [27:0] rows [4] = '{{16'h0ABC, 12'hABC}, {16'h7123, 12'h123},
		{16'h9456, 12'h456}, {16'hF789, 12'h789}};
	quad_conv_control uut (.*);
	host_ctl host (.*);
	initial forever #5 CLOCK = ~CLOCK;
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge CLOCK) if (++cycles == 8000) begin num_errors++; conclude(); end
	task automatic check(input logic [47:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rst_to(input logic s);
		RESET_CODE_SELECT = s;
		@(negedge CLOCK) RESET_N = 0;
		repeat (6) @(negedge CLOCK);
		check({OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D}, {4{s, 11'h000}});
		check(CHANNEL_SELECT, 2'h0);
		RESET_N = 1;
		repeat (6) @(negedge CLOCK);
		check({OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D}, {4{s, 11'h000}});
	endtask
	initial
	begin
		repeat (10) @(negedge CLOCK);
		RST = 0;
		check(OUT_CODE_D, 12'h000);
		foreach (rows[i])
		begin
			host.send(rows[i][27:12], 1, i[0]);
			check(i == 0 ? OUT_CODE_A : i == 1 ? OUT_CODE_B : i == 2 ? OUT_CODE_C : OUT_CODE_D,
				rows[i][11:0]);
			check(CHANNEL_SELECT, rows[i][27:26]);
		end
		host.send(16'h0555, 0, 0);
		check(OUT_CODE_A, 12'hABC);
		host.upd();
		check({OUT_CODE_A, OUT_CODE_B}, 24'h555123);
		rst_to(1);
		rst_to(0);
		conclude();
	end
endmodule // testbench
